/* design/snp_pkg.sv */
// package: constants and types of the serial nonvolatile memory front end
package snp_pkg;

   // ************************************************************
   // command bytes
   // ************************************************************
   localparam logic [7:0] OP_SET_WL = 8'h06;
   localparam logic [7:0] OP_CLR_WL = 8'h04;
   localparam logic [7:0] OP_SR_RD = 8'h05;
   localparam logic [7:0] OP_SR_WR = 8'h01;
   localparam logic [7:0] OP_MEM_RD = 8'h03;
   localparam logic [7:0] OP_MEM_WR = 8'h02;

   // ************************************************************
   // status byte layout and geometry
   // ************************************************************
   localparam int SR_PPE_BIT = 7;
   localparam int SR_BPH_BIT = 3;
   localparam int SR_BPL_BIT = 2;
   localparam int SR_WL_BIT = 1;
   localparam int ADDR_W = 11;
   localparam int BYTE_W = 8;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] BP_NONE = 2'h0;
   localparam logic [1:0] BP_QUARTER = 2'h1;
   localparam logic [1:0] BP_HALF = 2'h2;

   typedef struct packed {
      logic pin_protect_enable;
      logic block_protect_hi;
      logic block_protect_lo;
   } snp_nv_s;

   // nonvolatile bits as delivered (all clear)
   localparam snp_nv_s NV_INIT = 3'h0;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
      logic wp_n;
   } snp_pins_s;

   localparam snp_pins_s PINS_IDLE = 4'h9;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_CMD = 4'h1,
      ST_ADDR_HI = 4'h2,
      ST_ADDR_LO = 4'h3,
      ST_MEM_RD = 4'h4,
      ST_MEM_WR = 4'h5,
      ST_SR_RD = 4'h6,
      ST_SR_WR = 4'h7,
      ST_IGNORE = 4'h8
   } snp_state_e;

endpackage

/* design/snp_spi_nvram.sv */
// module: serial slave front end with write latch and protection
`timescale 1ns/1ps

module snp_spi_nvram
   import snp_pkg::*;
#(
   parameter int P_ADDR_W = ADDR_W
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_cs_n,
   input wire logic i_sck,
   input wire logic i_si,
   input wire logic i_wp_n,
   output logic o_so,
   output logic o_so_oe,
   output logic o_mode3
);

   // ************************************************************
   // parameter check
   // ************************************************************
   generate
      if (P_ADDR_W < 9 || P_ADDR_W > 16) begin : g_bad_addr
         $error("address width must lie in 9..16");
      end
   endgenerate

   // ************************************************************
   // storage
   // ************************************************************
   logic [BYTE_W-1:0] mem [0:(1<<P_ADDR_W)-1];
   snp_nv_s nv_reg = NV_INIT;

   snp_pins_s pin_m_reg;
   snp_pins_s pin_s_reg;
   logic sck_d_reg;
   logic cs_d_reg;
   snp_state_e state_reg;
   snp_state_e state_next;
   snp_state_e cmd_state;
   logic [2:0] cnt_reg;
   logic [BYTE_W-1:0] sh_reg;
   logic [BYTE_W-1:0] out_reg;
   logic [BYTE_W-1:0] out_next;
   logic [P_ADDR_W-1:0] addr_reg;
   logic [P_ADDR_W-1:0] addr_next;
   logic wel_reg;
   logic wr_op_reg;
   logic is_rd_reg;
   logic mode3_reg;
   logic so_reg;
   logic so_oe_reg;
   logic [BYTE_W-1:0] sr_byte;

   // ************************************************************
   // pin synchronisers and edge finding
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pin_m_reg <= PINS_IDLE;
         pin_s_reg <= PINS_IDLE;
         sck_d_reg <= 1'b0;
         cs_d_reg <= 1'b1;
      end else begin
         pin_m_reg <= {i_cs_n, i_sck, i_si, i_wp_n};
         pin_s_reg <= pin_m_reg;
         sck_d_reg <= pin_s_reg.sck;
         cs_d_reg <= pin_s_reg.cs_n;
      end
   end

   wire sel = !pin_s_reg.cs_n;
   wire cs_fall = cs_d_reg && sel;
   wire cs_rise = !cs_d_reg && !sel;
   // clock and data are looked at only while selected
   wire sck_rise = sel && pin_s_reg.sck && !sck_d_reg;
   wire sck_fall = sel && !pin_s_reg.sck && sck_d_reg;
   wire [BYTE_W-1:0] byte_in = {sh_reg[BYTE_W-2:0], pin_s_reg.si};
   wire byte_done = sck_rise && (cnt_reg == BIT_LAST);

   // ************************************************************
   // decoding
   // ************************************************************
   function automatic snp_state_e decode_cmd(input logic [7:0] op);
      case (op)
         OP_SR_RD: decode_cmd = ST_SR_RD;
         OP_SR_WR: decode_cmd = ST_SR_WR;
         OP_MEM_RD: decode_cmd = ST_ADDR_HI;
         OP_MEM_WR: decode_cmd = ST_ADDR_HI;
         default: decode_cmd = ST_IGNORE;
      endcase
   endfunction

   function automatic logic blk_protected(input logic [1:0] bp,
                                          input logic [P_ADDR_W-1:0] a);
      case (bp)
         BP_NONE: blk_protected = 1'b0;
         BP_QUARTER: blk_protected = &a[P_ADDR_W-1 -: 2];
         BP_HALF: blk_protected = a[P_ADDR_W-1];
         default: blk_protected = 1'b1;
      endcase
   endfunction

   assign cmd_state = decode_cmd(byte_in);
   wire [1:0] bp = {nv_reg.block_protect_hi, nv_reg.block_protect_lo};
   wire [P_ADDR_W-1:0] addr_inc = addr_reg + 1'b1;
   wire [P_ADDR_W-1:0] addr_lo_ld = {addr_reg[P_ADDR_W-1:BYTE_W], byte_in};
   wire [P_ADDR_W-1:0] rd_addr = (state_reg == ST_ADDR_LO) ?
                                 addr_lo_ld : addr_inc;
   wire in_mem_op = (state_reg == ST_MEM_RD) || (state_reg == ST_MEM_WR);
   wire out_state = (state_reg == ST_MEM_RD) || (state_reg == ST_SR_RD);
   wire cmd_done = byte_done && (state_reg == ST_CMD);
   // protect pin is absent from the memory path
   wire mem_we = byte_done && (state_reg == ST_MEM_WR) && wel_reg &&
                 !blk_protected(bp, addr_reg);
   wire sr_blocked = nv_reg.pin_protect_enable && !pin_s_reg.wp_n;
   wire sr_we = byte_done && (state_reg == ST_SR_WR) && wel_reg &&
                !sr_blocked;

   always_comb begin
      sr_byte = '0;
      sr_byte[SR_PPE_BIT] = nv_reg.pin_protect_enable;
      sr_byte[SR_BPH_BIT] = nv_reg.block_protect_hi;
      sr_byte[SR_BPL_BIT] = nv_reg.block_protect_lo;
      sr_byte[SR_WL_BIT] = wel_reg;
   end

   // ************************************************************
   // sequencing
   // ************************************************************
   always_comb begin
      state_next = state_reg;
      if (!sel) begin
         state_next = ST_IDLE;
      end else if (cs_fall) begin
         state_next = ST_CMD;
      end else if (byte_done) begin
         unique case (state_reg)
            ST_CMD: state_next = cmd_state;
            ST_ADDR_HI: state_next = ST_ADDR_LO;
            ST_ADDR_LO: state_next = is_rd_reg ? ST_MEM_RD : ST_MEM_WR;
            ST_SR_WR: state_next = ST_IGNORE;
            default: state_next = state_reg;
         endcase
      end
   end

   always_comb begin
      addr_next = addr_reg;
      out_next = out_reg;
      if (byte_done) begin
         unique case (state_reg)
            ST_ADDR_HI:
               addr_next[P_ADDR_W-1:BYTE_W] =
                  byte_in[P_ADDR_W-BYTE_W-1:0];
            ST_ADDR_LO: begin
               addr_next = addr_lo_ld;
               out_next = mem[rd_addr];
            end
            ST_MEM_RD: begin
               addr_next = addr_inc;
               out_next = mem[rd_addr];
            end
            ST_MEM_WR: addr_next = addr_inc;
            ST_SR_RD: out_next = sr_byte;
            ST_CMD: out_next = sr_byte;
            default: out_next = out_reg;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 3'h0;
         sh_reg <= 8'h00;
         out_reg <= 8'h00;
         addr_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= (!sel || cs_fall) ? 3'h0 : cnt_reg + 3'(sck_rise);
         sh_reg <= sck_rise ? byte_in : sh_reg;
         out_reg <= out_next;
         addr_reg <= addr_next;
      end
   end

   // ************************************************************
   // write latch and mode capture
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wel_reg <= 1'b0;
         wr_op_reg <= 1'b0;
         is_rd_reg <= 1'b0;
         mode3_reg <= 1'b0;
      end else begin
         if (cs_rise && wr_op_reg) begin
            wel_reg <= 1'b0;
         end else if (cmd_done && byte_in == OP_SET_WL) begin
            wel_reg <= 1'b1;
         end else if (cmd_done && byte_in == OP_CLR_WL) begin
            wel_reg <= 1'b0;
         end
         if (cs_rise) begin
            wr_op_reg <= 1'b0;
         end else if (cmd_done) begin
            wr_op_reg <= (byte_in == OP_MEM_WR) || (byte_in == OP_SR_WR);
         end
         if (cmd_done) begin
            is_rd_reg <= (byte_in == OP_MEM_RD);
         end
         if (cs_fall) begin
            mode3_reg <= pin_s_reg.sck;
         end
      end
   end

   // ************************************************************
   // nonvolatile store, untouched by reset
   // ************************************************************
   always_ff @(posedge i_clk) begin
      if (mem_we) begin
         mem[addr_reg] <= byte_in;
      end
      if (sr_we) begin
         // written flag position is dropped
         nv_reg <= {byte_in[SR_PPE_BIT], byte_in[SR_BPH_BIT],
                    byte_in[SR_BPL_BIT]};
      end
   end

   // ************************************************************
   // serial output
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         so_reg <= 1'b0;
         so_oe_reg <= 1'b0;
      end else if (!sel || !out_state) begin
         so_reg <= 1'b0;
         so_oe_reg <= 1'b0;
      end else if (sck_fall) begin
         so_reg <= out_reg[BIT_LAST - cnt_reg];
         so_oe_reg <= 1'b1;
      end
   end

   assign o_so = so_reg;
   assign o_so_oe = so_oe_reg;
   assign o_mode3 = mode3_reg;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);

   chk_oe_read_only: assert property (
      o_so_oe |-> $past(out_state) && $past(sel))
      else $error("output driven outside a read");

   chk_deselect_idle: assert property (
      !sel |=> state_reg == ST_IDLE && !o_so_oe)
      else $error("not idle while deselected");

   chk_set_latch: assert property (
      cmd_done && byte_in == OP_SET_WL |=> wel_reg && sr_byte[SR_WL_BIT])
      else $error("set command did not set the latch");

   chk_clear_latch: assert property (
      cmd_done && byte_in == OP_CLR_WL |=> !wel_reg ##1 !sr_we && !mem_we)
      else $error("clear command left writes enabled");

   chk_write_autoclr: assert property (
      cs_rise && wr_op_reg |=> !wel_reg)
      else $error("latch survived a write");

   chk_mem_guard: assert property (
      mem_we |-> wel_reg && !(bp == 2'h3) && $past(state_reg) != ST_IDLE)
      else $error("memory write while protected");

   chk_sr_guard: assert property (
      sr_we |=> nv_reg.pin_protect_enable == $past(byte_in[SR_PPE_BIT]) &&
               !$past(sr_blocked) && $past(wel_reg))
      else $error("status write taken while blocked");

   chk_addr_step: assert property (
      byte_done && in_mem_op |=> addr_reg == $past(addr_inc))
      else $error("address did not advance");

   chk_so_on_fall: assert property (
      $changed(o_so) && sel && $past(sel) |-> $past(sck_fall))
      else $error("output changed away from a falling edge");

   chk_status_zero: assert property (
      sr_we |=> sr_byte[6:4] == 3'h0 && !sr_byte[0])
      else $error("fixed status bits not zero");

endmodule

/* verification/snp_host_model.sv */
// host model: serial bus master driving the device pins
`timescale 1ns/1ps
module snp_host_model
   import snp_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_so_line,
   output snp_pins_s o_pins
);
   logic idle_hi = 1'b0;
   initial o_pins = PINS_IDLE;

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   // select falls with the clock already at its idle level
   task automatic start(input logic m3);
      idle_hi = m3;
      o_pins.sck <= m3;
      cyc(3);
      o_pins.cs_n <= 1'b0;
      cyc(3);
   endtask

   // bit set up while clock low, read back at the rise
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         o_pins.sck <= 1'b0;
         o_pins.si <= tx[i];
         cyc(5);
         rx[i] = i_so_line;
         o_pins.sck <= 1'b1;
         cyc(3);
      end
   endtask

   // released data line shows the inverse of its last level
   task automatic stop();
      o_pins.sck <= idle_hi;
      cyc(2);
      o_pins.cs_n <= 1'b1;
      o_pins.si <= ~o_pins.si;
      cyc(4);
   endtask

   task automatic set_wp(input logic v);
      o_pins.wp_n <= v;
      cyc(1);
   endtask
endmodule

/* verification/spi_nvram_command_protect_tb_top.sv */
// testbench: command, latch and protection checks at the pins
`timescale 1ns/1ps
module spi_nvram_command_protect_tb_top
   import snp_pkg::*;
();
   logic clk;
   logic arst_n;
   wire snp_pins_s pins;
   logic so;
   logic so_oe;
   logic mode3;
   wire so_line;
   int num_errors = 0;
   int comparisons = 0;
   logic [7:0] r0;
   logic [7:0] r1;

   assign so_line = so_oe ? so : 1'bz;

   snp_spi_nvram i_snp_spi_nvram (
      .i_clk(clk), .i_arst_n(arst_n), .i_cs_n(pins.cs_n),
      .i_sck(pins.sck), .i_si(pins.si), .i_wp_n(pins.wp_n),
      .o_so(so), .o_so_oe(so_oe), .o_mode3(mode3));

   snp_host_model i_snp_host_model (
      .i_clk(clk), .i_so_line(so_line), .o_pins(pins));

   // ************************************************************
   // helpers
   // ************************************************************
   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic bz(input logic [7:0] b);
      logic [7:0] r;
      i_snp_host_model.xfer(b, r);
      check("so released", r, 8'hZZ);
   endtask

   task automatic cmd(input logic [7:0] op, input logic m3);
      i_snp_host_model.start(m3);
      bz(op);
      i_snp_host_model.stop();
   endtask

   task automatic rd_sr(output logic [7:0] q);
      i_snp_host_model.start(1'b0);
      bz(OP_SR_RD);
      i_snp_host_model.xfer(8'h00, q);
      i_snp_host_model.stop();
   endtask

   task automatic wr_sr(input logic [7:0] v, input logic en);
      if (en) cmd(OP_SET_WL, 1'b0);
      i_snp_host_model.start(1'b0);
      bz(OP_SR_WR);
      bz(v);
      i_snp_host_model.stop();
   endtask

   task automatic mem_wr(input logic [15:0] a, input logic [7:0] d0, d1,
                         input logic en, input logic two);
      if (en) cmd(OP_SET_WL, 1'b0);
      i_snp_host_model.start(1'b0);
      bz(OP_MEM_WR);
      bz(a[15:8]);
      bz(a[7:0]);
      bz(d0);
      if (two) bz(d1);
      i_snp_host_model.stop();
   endtask

   task automatic mem_rd(input logic [15:0] a, output logic [7:0] q0, q1);
      i_snp_host_model.start(1'b0);
      bz(OP_MEM_RD);
      bz(a[15:8]);
      bz(a[7:0]);
      i_snp_host_model.xfer(8'h00, q0);
      i_snp_host_model.xfer(8'h00, q1);
      i_snp_host_model.stop();
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_reset();
      rd_sr(r0);
      check("status after reset", r0, 8'h00);
      check("mode flag", {7'h00, mode3}, 8'h00);
   endtask

   task automatic t_latch();
      cmd(OP_SET_WL, 1'b1);
      check("mode flag", {7'h00, mode3}, 8'h01);
      rd_sr(r0);
      check("latch set", r0, 8'h02);
      cmd(OP_CLR_WL, 1'b1);
      rd_sr(r0);
      check("latch clear", r0, 8'h00);
   endtask

   task automatic t_unknown();
      i_snp_host_model.start(1'b0);
      bz(8'hFF);
      bz(OP_SET_WL);
      i_snp_host_model.stop();
      rd_sr(r0);
      check("latch after ignored frame", r0, 8'h00);
   endtask

   task automatic t_status();
      wr_sr(8'hFF, 1'b1);
      rd_sr(r0);
      check("status write", r0, 8'h8C);
      i_snp_host_model.set_wp(1'b0);
      wr_sr(8'h00, 1'b1);
      rd_sr(r0);
      check("pin blocks status", r0, 8'h8C);
      i_snp_host_model.set_wp(1'b1);
      wr_sr(8'h00, 1'b0);
      rd_sr(r0);
      check("status without latch", r0, 8'h8C);
      wr_sr(8'h00, 1'b1);
      i_snp_host_model.set_wp(1'b0);
      wr_sr(8'h08, 1'b1);
      rd_sr(r0);
      check("pin ignored", r0, 8'h08);
   endtask

   task automatic t_block();
      logic [10:0] pa [4];
      logic [7:0] sh [4];
      logic prot;
      logic [7:0] d;
      pa = '{11'h000, 11'h3FF, 11'h400, 11'h600};
      sh = '{default: 8'h00};
      for (int bp = 0; bp < 4; bp++) begin
         wr_sr({4'h0, bp[1:0], 2'h0}, 1'b1);
         rd_sr(r0);
         check("block bits", r0, {4'h0, bp[1:0], 2'h0});
         for (int j = 0; j < 4; j++) begin
            prot = bp == 3 || (bp == 2 && pa[j][10]) ||
                   (bp == 1 && pa[j][10:9] == 2'h3);
            d = 8'(bp * 16 + j + 1);
            mem_wr({5'h00, pa[j]}, d, 8'h00, 1'b1, 1'b0);
            if (!prot) sh[j] = d;
            mem_rd({5'h00, pa[j]}, r0, r1);
            check("probe byte", r0, sh[j]);
         end
      end
   endtask

   task automatic t_guard();
      wr_sr(8'h00, 1'b1);
      // second byte gives the refused location a known value
      mem_wr(16'h0020, 8'hAA, 8'h00, 1'b1, 1'b1);
      rd_sr(r0);
      check("latch after write", r0, 8'h00);
      mem_wr(16'h0021, 8'h55, 8'h00, 1'b0, 1'b0);
      mem_rd(16'h0020, r0, r1);
      check("written byte", r0, 8'hAA);
      check("refused byte", r1, 8'h00);
   endtask

   task automatic t_wrap();
      mem_wr(16'hF7FF, 8'h3C, 8'hC3, 1'b1, 1'b1);
      mem_rd(16'h07FF, r0, r1);
      check("top byte", r0, 8'h3C);
      check("wrapped byte", r1, 8'hC3);
   endtask

   // power cycle while deselected: latch and mode drop, protect bits stay
   task automatic t_retain();
      wr_sr(8'h88, 1'b1);
      cmd(OP_SET_WL, 1'b1);
      check("mode before reset", {7'h00, mode3}, 8'h01);
      arst_n <= 1'b0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      check("mode after reset", {7'h00, mode3}, 8'h00);
      rd_sr(r0);
      check("status after power cycle", r0, 8'h88);
   endtask

   task automatic summarize();
      $display("Comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      arst_n = 1'b0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_latch();
      t_unknown();
      t_status();
      t_block();
      t_guard();
      t_wrap();
      t_retain();
      summarize();
   end

   // run needs about 17000 cycles
   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      summarize();
   end
endmodule
